// ==== design/uif_core.sv ====
`timescale 1ns/100ps
`default_nettype none
module uif_core
	import uif_pkg::*;
#(
	parameter int IDLE_CYC = UIF_IDLE_CYC,
	parameter int DEPTH = UIF_FIFO_DEPTH
) (
	input wire logic clk, // 40 MHz clock
	input wire logic rstn, // Async reset, active low
	input wire logic host_role_enable, // Host role selected
	input wire uif_events_t ev, // Event pulses from engine
	input wire uif_token_t token_rec, // Record taken with token_done
	input wire uif_line_t line, // Sampled line state
	input wire logic [UIF_ADDR_W-1:0] wb_adr_i, // Byte address
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [3:0] wb_sel_i, // Byte selects
	input wire logic wb_we_i, // Write enable
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	output logic [7:0] transfer_status, // FIFO head record
	output logic token_fifo_full, // Engine must hold tokens
	output logic module_irq // Module interrupt
);
	localparam int RCW = $clog2(UIF_RESUME_CYC + 1);
	localparam int ACW = $clog2(UIF_ATTACH_CYC + 1);
	localparam int ICW = $clog2(IDLE_CYC + 1);
	localparam int TCW = $clog2(UIF_TURN_CYC + 2);
	localparam int PW = $clog2(DEPTH);

	logic [7:0] flags_reg;
	logic [7:0] enables_reg;
	logic [7:0] err_flags_reg;
	logic [7:0] err_enables_reg;
	logic [7:0] flags_view;
	logic [7:0] flags_set;
	logic [7:0] err_set;
	logic [7:0] flags_clr;
	logic [7:0] err_clr;
	logic ack_reg;
	logic wr_go;
	logic [RCW-1:0] resume_cnt_reg;
	logic [ACW-1:0] attach_cnt_reg;
	logic [ICW-1:0] idle_cnt_reg;
	logic [TCW-1:0] turn_cnt_reg;
	logic turn_wait_reg;
	logic resume_hit;
	logic attach_hit;
	logic idle_hit;
	logic turn_hit;
	logic attached_reg;
	uif_token_t fifo_mem [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] count_reg;
	logic fifo_push;
	logic fifo_pop;
	logic token_pending;

	function automatic logic [7:0] w1c_mask(input logic [31:0] d, input logic [3:0] sel);
		w1c_mask = sel[0] ? d[7:0] : 8'h00;
	endfunction : w1c_mask

	// Bus slave: one wait state, ack drops the cycle after it is given
	assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
		end
	end
	assign wb_ack_o = ack_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg) begin
			case (wb_adr_i)
				UIF_OFS_FLAGS: wb_dat_o <= {24'h00_0000, flags_view};
				UIF_OFS_ENABLES: wb_dat_o <= {24'h00_0000, enables_reg};
				UIF_OFS_ERR_FLAGS: wb_dat_o <= {24'h00_0000, err_flags_reg};
				UIF_OFS_ERR_ENABLES: wb_dat_o <= {24'h00_0000, err_enables_reg};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	assign flags_clr = (wr_go && wb_adr_i == UIF_OFS_FLAGS) ? w1c_mask(wb_dat_i, wb_sel_i) : 8'h00;
	assign err_clr = (wr_go && wb_adr_i == UIF_OFS_ERR_FLAGS) ? w1c_mask(wb_dat_i, wb_sel_i) : 8'h00;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			enables_reg <= UIF_RST_ENABLES;
			err_enables_reg <= UIF_RST_ENABLES;
		end else if (wr_go && wb_sel_i[0]) begin
			if (wb_adr_i == UIF_OFS_ENABLES) begin
				enables_reg <= wb_dat_i[7:0];
			end
			if (wb_adr_i == UIF_OFS_ERR_ENABLES) begin
				err_enables_reg <= wb_dat_i[7:0];
			end
		end
	end

	// Resume: K held 2.5 us
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			resume_cnt_reg <= '0;
		end else if (!line.k_state) begin
			resume_cnt_reg <= '0;
		end else if (resume_cnt_reg != RCW'(UIF_RESUME_CYC)) begin
			resume_cnt_reg <= resume_cnt_reg + 1'b1;
		end
	end
	assign resume_hit = line.k_state && resume_cnt_reg == RCW'(UIF_RESUME_CYC - 1);

	// Attach: host role, quiet and not SE0 for 2.5 us; fires once per attachment
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			attach_cnt_reg <= '0;
		end else if (!host_role_enable || line.se0 || !line.j_idle) begin
			attach_cnt_reg <= '0;
		end else if (attach_cnt_reg != ACW'(UIF_ATTACH_CYC)) begin
			attach_cnt_reg <= attach_cnt_reg + 1'b1;
		end
	end
	assign attach_hit = host_role_enable && !line.se0 && line.j_idle && !attached_reg
		&& attach_cnt_reg == ACW'(UIF_ATTACH_CYC - 1);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			attached_reg <= 1'b0;
		end else if (!host_role_enable || ev.detach) begin
			attached_reg <= 1'b0;
		end else if (attach_hit) begin
			attached_reg <= 1'b1;
		end
	end

	// Idle: 3 ms of unbroken idle bus
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idle_cnt_reg <= '0;
		end else if (!line.j_idle) begin
			idle_cnt_reg <= '0;
		end else if (idle_cnt_reg != ICW'(IDLE_CYC)) begin
			idle_cnt_reg <= idle_cnt_reg + 1'b1;
		end
	end
	assign idle_hit = line.j_idle && idle_cnt_reg == ICW'(IDLE_CYC - 1);

	// Turnaround: armed by EOP, disarmed by a response
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			turn_wait_reg <= 1'b0;
			turn_cnt_reg <= '0;
		end else if (ev.eop) begin
			turn_wait_reg <= 1'b1;
			turn_cnt_reg <= '0;
		end else if (ev.response || !line.j_idle || turn_hit) begin
			turn_wait_reg <= 1'b0;
		end else if (turn_wait_reg) begin
			turn_cnt_reg <= turn_cnt_reg + 1'b1;
		end
	end
	assign turn_hit = turn_wait_reg && !ev.response && line.j_idle
		&& turn_cnt_reg == TCW'(UIF_TURN_CYC);

	// Error set terms
	always_comb begin
		err_set = 8'h00;
		err_set[UIF_E_STUFF] = ev.bit_stuff;
		err_set[UIF_E_BMX] = ev.bmx_addr;
		err_set[UIF_E_DMA] = ev.dma_late;
		err_set[UIF_E_TURN] = turn_hit;
		err_set[UIF_E_SIZE] = ev.size_odd;
		err_set[UIF_E_CRC16] = ev.crc16;
		err_set[UIF_E_CRC5_EOF] = host_role_enable ? (ev.frame_zero & line.xfer_busy) : ev.crc5;
		err_set[UIF_E_PID] = ev.pid_bad;
	end

	// Set wins over a simultaneous clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			err_flags_reg <= UIF_RST_FLAGS;
		end else begin
			err_flags_reg <= (err_flags_reg & ~err_clr) | err_set;
		end
	end

	always_comb begin
		flags_set = 8'h00;
		flags_set[UIF_B_STALL] = ev.stall;
		flags_set[UIF_B_ATTACH] = attach_hit;
		flags_set[UIF_B_RESUME] = resume_hit;
		flags_set[UIF_B_IDLE] = idle_hit;
		flags_set[UIF_B_TOKEN] = 1'b0;
		flags_set[UIF_B_FRAME] = ev.sof;
		flags_set[UIF_B_RESET] = host_role_enable ? ev.detach : ev.bus_reset;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flags_reg <= UIF_RST_FLAGS;
		end else begin
			flags_reg <= (flags_reg & ~flags_clr) | flags_set;
		end
	end

	// Token-done mirrors FIFO occupancy, so each clear exposes the next entry
	assign token_pending = count_reg != '0;
	// Error summary follows the masked error flags, read-only
	always_comb begin
		flags_view = flags_reg;
		flags_view[UIF_B_TOKEN] = token_pending;
		flags_view[UIF_B_ERRSUM] = |(err_flags_reg & err_enables_reg);
	end

	// Status FIFO; engine must honour full, an extra token is dropped
	assign fifo_push = ev.token_done && count_reg != (PW+1)'(DEPTH);
	assign fifo_pop = token_pending && flags_clr[UIF_B_TOKEN];
	assign token_fifo_full = count_reg == (PW+1)'(DEPTH);

	always_ff @(posedge clk) begin
		if (fifo_push) begin
			fifo_mem[wr_ptr_reg] <= token_rec;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (fifo_push) begin
				wr_ptr_reg <= PW'(wr_ptr_reg + 1'b1);
			end
			if (fifo_pop) begin
				rd_ptr_reg <= PW'(rd_ptr_reg + 1'b1);
			end
			count_reg <= (PW+1)'(count_reg + (PW+1)'(fifo_push) - (PW+1)'(fifo_pop));
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			transfer_status <= 8'h00;
		end else if (count_reg != '0 || fifo_push) begin
			transfer_status <= {fifo_mem[fifo_pop ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg], 2'b00};
		end
	end

	// Enable bit 0 covers reset or detach since bit 0 is already role-selected
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			module_irq <= 1'b0;
		end else begin
			module_irq <= |(flags_view & enables_reg);
		end
	end

	// Assertions
	// A broken condition or a fresh EOP must hold the resume, idle and turnaround flags off for a while
	sequence s_no_resume;
		!resume_hit [*8];
	endsequence
	sequence s_no_idle;
		!idle_hit [*8];
	endsequence
	sequence s_turn_quiet;
		!turn_hit [*8];
	endsequence

	a_errsum_masked: assert property (@(posedge clk) disable iff (!rstn)
		(err_flags_reg & err_enables_reg) == 8'h00 && (err_set & err_enables_reg) == 8'h00
			&& !(wr_go && wb_adr_i == UIF_OFS_ERR_ENABLES) |=> !flags_view[UIF_B_ERRSUM])
		else $error("error summary set by masked error");
	a_irq_follows: assert property (@(posedge clk) disable iff (!rstn)
		module_irq == $past(|(flags_view & enables_reg)))
		else $error("interrupt does not follow enabled flags");
	a_err_w0_hold: assert property (@(posedge clk) disable iff (!rstn)
		$past(err_flags_reg[0]) && !$past(err_clr[0]) |-> err_flags_reg[0])
		else $error("error flag lost without write 1");
	a_err_w1_clear: assert property (@(posedge clk) disable iff (!rstn)
		$past(err_clr[7]) && !$past(err_set[7]) |-> !err_flags_reg[7])
		else $error("error flag not cleared by write 1");
	a_stall_sets: assert property (@(posedge clk) disable iff (!rstn)
		ev.stall |=> flags_reg[UIF_B_STALL])
		else $error("stall flag not set");
	a_resume_time: assert property (@(posedge clk) disable iff (!rstn)
		!line.k_state |=> s_no_resume)
		else $error("resume set before K held");
	a_token_pop: assert property (@(posedge clk) disable iff (!rstn)
		fifo_pop && !fifo_push |=> count_reg == $past(count_reg) - 1'b1)
		else $error("token clear did not advance fifo");
	a_bit0_role: assert property (@(posedge clk) disable iff (!rstn)
		ev.bus_reset && !host_role_enable |=> flags_reg[UIF_B_RESET])
		else $error("bus reset flag not set in peripheral role");
	a_errsum_gate: assert property (@(posedge clk) disable iff (!rstn)
		!enables_reg[UIF_B_ERRSUM] && (flags_view & enables_reg) == 8'h00 |=> !module_irq)
		else $error("interrupt without enabled source");
	a_stuff_sets: assert property (@(posedge clk) disable iff (!rstn)
		ev.bit_stuff |=> err_flags_reg[UIF_E_STUFF])
		else $error("bit stuff flag not set");
	a_bmx_sets: assert property (@(posedge clk) disable iff (!rstn)
		ev.bmx_addr |=> err_flags_reg[UIF_E_BMX])
		else $error("bus matrix flag not set");
	a_dma_sets: assert property (@(posedge clk) disable iff (!rstn)
		ev.dma_late |=> err_flags_reg[UIF_E_DMA])
		else $error("dma error flag not set");
	a_size_sets: assert property (@(posedge clk) disable iff (!rstn)
		ev.size_odd |=> err_flags_reg[UIF_E_SIZE])
		else $error("data size flag not set");
	a_crc16_sets: assert property (@(posedge clk) disable iff (!rstn)
		ev.crc16 |=> err_flags_reg[UIF_E_CRC16])
		else $error("data crc flag not set");
	a_crc5_dev: assert property (@(posedge clk) disable iff (!rstn)
		!host_role_enable && ev.crc5 |=> err_flags_reg[UIF_E_CRC5_EOF])
		else $error("token crc flag not set");
	a_eof_host: assert property (@(posedge clk) disable iff (!rstn)
		host_role_enable && ev.frame_zero && line.xfer_busy |=> err_flags_reg[UIF_E_CRC5_EOF])
		else $error("end of frame flag not set");
	a_pid_sets: assert property (@(posedge clk) disable iff (!rstn)
		ev.pid_bad |=> err_flags_reg[UIF_E_PID])
		else $error("pid flag not set");
	a_sof_sets: assert property (@(posedge clk) disable iff (!rstn)
		ev.sof |=> flags_reg[UIF_B_FRAME])
		else $error("frame start flag not set");
	a_detach_host: assert property (@(posedge clk) disable iff (!rstn)
		ev.detach && host_role_enable |=> flags_reg[UIF_B_RESET])
		else $error("detach flag not set in host role");
	a_turn_early: assert property (@(posedge clk) disable iff (!rstn)
		ev.eop |=> s_turn_quiet)
		else $error("turnaround timeout too early");
	a_idle_time: assert property (@(posedge clk) disable iff (!rstn)
		!line.j_idle |=> s_no_idle)
		else $error("idle set on a broken idle bus");
	a_irq_errors: assert property (@(posedge clk) disable iff (!rstn)
		|(err_flags_reg & err_enables_reg) && enables_reg[UIF_B_ERRSUM] |=> module_irq)
		else $error("enabled error did not raise interrupt");
	a_flag_w1c: assert property (@(posedge clk) disable iff (!rstn)
		$past(flags_clr[UIF_B_STALL]) && !$past(flags_set[UIF_B_STALL]) |-> !flags_reg[UIF_B_STALL])
		else $error("event flag not cleared by write 1");
	a_token_flag: assert property (@(posedge clk) disable iff (!rstn)
		ev.token_done && count_reg == '0 |=> flags_view[UIF_B_TOKEN])
		else $error("token done flag not set");
	a_fifo_bound: assert property (@(posedge clk) disable iff (!rstn)
		count_reg <= (PW+1)'(DEPTH))
		else $error("status fifo overfilled");
endmodule : uif_core
`default_nettype wire

// ==== design/uif_pkg.sv ====
package uif_pkg;
	// Register byte addresses on the Wishbone slave
	localparam logic [3:0] UIF_OFS_FLAGS = 4'h0;
	localparam logic [3:0] UIF_OFS_ENABLES = 4'h4;
	localparam logic [3:0] UIF_OFS_ERR_FLAGS = 4'h8;
	localparam logic [3:0] UIF_OFS_ERR_ENABLES = 4'hc;
	localparam logic [3:0] UIF_OFS_STATUS = 4'h0;
	localparam int UIF_ADDR_W = 4;

	// Event flag positions
	localparam int UIF_B_STALL = 7;
	localparam int UIF_B_ATTACH = 6;
	localparam int UIF_B_RESUME = 5;
	localparam int UIF_B_IDLE = 4;
	localparam int UIF_B_TOKEN = 3;
	localparam int UIF_B_FRAME = 2;
	localparam int UIF_B_ERRSUM = 1;
	localparam int UIF_B_RESET = 0;

	// Error flag positions
	localparam int UIF_E_STUFF = 7;
	localparam int UIF_E_BMX = 6;
	localparam int UIF_E_DMA = 5;
	localparam int UIF_E_TURN = 4;
	localparam int UIF_E_SIZE = 3;
	localparam int UIF_E_CRC16 = 2;
	localparam int UIF_E_CRC5_EOF = 1;
	localparam int UIF_E_PID = 0;

	localparam logic [7:0] UIF_RST_FLAGS = 8'h00;
	localparam logic [7:0] UIF_RST_ENABLES = 8'h00;

	// Timing at a 40 MHz clock
	localparam int UIF_CLK_HZ = 40000000;
	localparam int UIF_RESUME_NS = 2500;
	localparam int UIF_ATTACH_NS = 2500;
	localparam int UIF_IDLE_MS = 3;
	localparam int UIF_TURN_BITS = 16;
	localparam int UIF_BIT_HZ = 12000000;
	localparam int UIF_RESUME_CYC = (UIF_RESUME_NS * (UIF_CLK_HZ / 1000000) + 999) / 1000;
	localparam int UIF_ATTACH_CYC = (UIF_ATTACH_NS * (UIF_CLK_HZ / 1000000) + 999) / 1000;
	localparam int UIF_IDLE_CYC = UIF_IDLE_MS * (UIF_CLK_HZ / 1000);
	localparam int UIF_TURN_CYC = (UIF_TURN_BITS * UIF_CLK_HZ + UIF_BIT_HZ - 1) / UIF_BIT_HZ;
	localparam int UIF_FIFO_DEPTH = 4;

	// Events from the serial engine, one-cycle pulses
	typedef struct packed {
		logic stall;
		logic bus_reset;
		logic detach;
		logic sof;
		logic token_done;
		logic bit_stuff;
		logic bmx_addr;
		logic dma_late;
		logic crc16;
		logic crc5;
		logic frame_zero;
		logic size_odd;
		logic pid_bad;
		logic eop;
		logic response;
	} uif_events_t;

	// Completed-token record: endpoint, direction, odd bank
	typedef struct packed {
		logic [3:0] endpoint;
		logic dir_tx;
		logic odd_bank;
	} uif_token_t;

	// Line state sampled from the transceiver
	typedef struct packed {
		logic k_state;
		logic j_idle;
		logic se0;
		logic xfer_busy;
	} uif_line_t;
endpackage : uif_pkg

// ==== tb/uif_usb_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module uif_usb_model
	import uif_pkg::*;
(
	input wire logic clk, // Module clock
	output var uif_events_t ev, // Engine event pulses
	output var uif_token_t token_rec, // Token record
	output var uif_line_t line // Line state
);
	initial begin
		ev = '0;
		token_rec = '0;
		line = '0;
	end

	// Record turns stale after the pulse, so a late sample reads garbage
	task automatic pulse(input uif_events_t e, input uif_token_t t);
		@(posedge clk);
		ev <= e;
		token_rec <= t;
		@(posedge clk);
		ev <= '0;
		token_rec <= ~t;
	endtask : pulse

	// Line state held unbroken for a count of cycles, then released
	task automatic hold_line(input uif_line_t l, input int cyc);
		@(posedge clk);
		line <= l;
		repeat (cyc) @(posedge clk);
		line <= '0;
	endtask : hold_line
endmodule : uif_usb_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
	import uif_pkg::*;
	localparam int IDLE = 50;
	logic clk, rstn, host, we, cyc, stb, ack, full, irq;
	logic [3:0] adr, sel;
	logic [31:0] wdat, rd, dat_o;
	logic [7:0] tstat;
	uif_events_t ev, e;
	uif_token_t trec, t;
	uif_line_t line, l;
	int n_mismatch = 0;
	int tests_run = 0;

	uif_usb_model pm (.clk(clk), .ev(ev), .token_rec(trec), .line(line));
	uif_core #(.IDLE_CYC(IDLE), .DEPTH(UIF_FIFO_DEPTH)) uut (.clk(clk), .rstn(rstn), .host_role_enable(host),
		.ev(ev), .token_rec(trec), .line(line), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .transfer_status(tstat),
		.token_fifo_full(full), .module_irq(irq));

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	// Caller stands just after a rising edge
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (ack === 1'h1) break;
		end
		if (i == 20) begin
			n_mismatch++;
			results();
		end
		rd = dat_o;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
		@(posedge clk);
	endtask : wb

	task automatic rdc(input logic [3:0] a, input logic [31:0] x, input string n);
		wb(1'h0, a, 32'h0);
		chk(n, rd, x);
	endtask : rdc

	task automatic t_reset;
		wb(1'h1, UIF_OFS_ENABLES, 32'hffffff00);
		rdc(UIF_OFS_FLAGS, 32'h0, "flags rst");
		rdc(UIF_OFS_ENABLES, 32'h0, "enables rst");
		rdc(UIF_OFS_ERR_FLAGS, 32'h0, "errors rst");
		rdc(UIF_OFS_ERR_ENABLES, 32'h0, "err enables rst");
		rdc(4'h2, 32'h0, "unmapped");
		chk("irq rst", irq, 32'h0);
	endtask : t_reset

	task automatic t_events;
		int i;
		int bits[3] = '{7, 2, 0};
		for (i = 0; i < 3; i++) begin
			e = '0;
			case (i)
				0: e.stall = 1'h1;
				1: e.sof = 1'h1;
				default: e.bus_reset = 1'h1;
			endcase
			pm.pulse(e, '0);
			rdc(UIF_OFS_FLAGS, 32'h1 << bits[i], "event flag");
			chk("masked irq", irq, 32'h0);
			wb(1'h1, UIF_OFS_ENABLES, 32'h1 << bits[i]);
			repeat (2) @(posedge clk);
			chk("irq", irq, 32'h1);
			wb(1'h1, UIF_OFS_FLAGS, 32'h0);
			rdc(UIF_OFS_FLAGS, 32'h1 << bits[i], "flag held");
			wb(1'h1, UIF_OFS_FLAGS, 32'h1 << bits[i]);
			repeat (2) @(posedge clk);
			chk("irq cleared", irq, 32'h0);
			wb(1'h1, UIF_OFS_ENABLES, 32'h0);
		end
		host <= 1'h1;
		e = '0;
		e.detach = 1'h1;
		pm.pulse(e, '0);
		wb(1'h0, UIF_OFS_FLAGS, 32'h0);
		chk("detach", rd[0], 32'h1);
		wb(1'h1, UIF_OFS_FLAGS, 32'hfd);
		host <= 1'h0;
	endtask : t_events

	// A condition broken off short of its time must not count
	task automatic t_line;
		l = '0;
		l.k_state = 1'h1;
		pm.hold_line(l, 90);
		wb(1'h0, UIF_OFS_FLAGS, 32'h0);
		chk("resume short", rd[5], 32'h0);
		pm.hold_line(l, 110);
		wb(1'h0, UIF_OFS_FLAGS, 32'h0);
		chk("resume", rd[5], 32'h1);
		wb(1'h1, UIF_OFS_FLAGS, 32'h20);
		l = '0;
		l.j_idle = 1'h1;
		pm.hold_line(l, IDLE - 10);
		wb(1'h0, UIF_OFS_FLAGS, 32'h0);
		chk("idle short", rd[4], 32'h0);
		host <= 1'h1;
		pm.hold_line(l, 110);
		wb(1'h0, UIF_OFS_FLAGS, 32'h0);
		chk("idle", rd[4], 32'h1);
		chk("attach", rd[6], 32'h1);
		wb(1'h1, UIF_OFS_FLAGS, 32'hfd);
		host <= 1'h0;
	endtask : t_line

	task automatic t_errors;
		int k;
		e = '0;
		e.crc16 = 1'h1;
		pm.pulse(e, '0);
		rdc(UIF_OFS_ERR_FLAGS, 32'h04, "crc16 flag");
		rdc(UIF_OFS_FLAGS, 32'h0, "masked summary");
		wb(1'h1, UIF_OFS_ERR_FLAGS, 32'h0);
		rdc(UIF_OFS_ERR_FLAGS, 32'h04, "error held");
		wb(1'h1, UIF_OFS_ERR_FLAGS, 32'h04);
		wb(1'h1, UIF_OFS_ERR_ENABLES, 32'hff);
		e = '0;
		e.pid_bad = 1'h1;
		pm.pulse(e, '0);
		rdc(UIF_OFS_FLAGS, 32'h02, "summary");
		chk("summary gated", irq, 32'h0);
		// Resume enable stays off: the module is never suspended here
		wb(1'h1, UIF_OFS_ENABLES, 32'h02);
		repeat (2) @(posedge clk);
		chk("summary irq", irq, 32'h1);
		wb(1'h1, UIF_OFS_ERR_FLAGS, 32'h01);
		for (k = 0; k < 8; k++) begin
			e = '0;
			case (k)
				0: e.bit_stuff = 1'h1;
				1: e.bmx_addr = 1'h1;
				2: e.dma_late = 1'h1;
				3: e.eop = 1'h1;
				4: e.size_odd = 1'h1;
				5: e.crc16 = 1'h1;
				6: e.crc5 = 1'h1;
				default: e.pid_bad = 1'h1;
			endcase
			if (k == 3) begin
				// Turnaround only counts on an idle bus, which also trips the idle flag
				l = '0;
				l.j_idle = 1'h1;
				fork
					pm.pulse(e, '0);
					pm.hold_line(l, UIF_TURN_CYC + 6);
				join
				wb(1'h1, UIF_OFS_FLAGS, 32'h10);
			end else begin
				pm.pulse(e, '0);
			end
			rdc(UIF_OFS_ERR_FLAGS, 32'h1 << (7 - k), "error flag");
			rdc(UIF_OFS_FLAGS, 32'h02, "summary set");
			chk("error irq", irq, 32'h1);
			wb(1'h1, UIF_OFS_ERR_FLAGS, 32'h1 << (7 - k));
			rdc(UIF_OFS_FLAGS, 32'h0, "summary follows");
		end
		e = '0;
		e.eop = 1'h1;
		l = '0;
		l.j_idle = 1'h1;
		fork
			begin
				pm.pulse(e, '0);
				e.eop = 1'h0;
				e.response = 1'h1;
				pm.pulse(e, '0);
			end
			pm.hold_line(l, UIF_TURN_CYC + 6);
		join
		wb(1'h1, UIF_OFS_FLAGS, 32'h10);
		rdc(UIF_OFS_ERR_FLAGS, 32'h0, "answered turnaround");
		host <= 1'h1;
		l = '0;
		l.xfer_busy = 1'h1;
		e = '0;
		e.frame_zero = 1'h1;
		fork
			pm.hold_line(l, 4);
			pm.pulse(e, '0);
		join
		wb(1'h0, UIF_OFS_ERR_FLAGS, 32'h0);
		chk("end of frame", rd[1], 32'h1);
		wb(1'h1, UIF_OFS_ERR_FLAGS, 32'hff);
		host <= 1'h0;
		wb(1'h1, UIF_OFS_ENABLES, 32'h0);
		wb(1'h1, UIF_OFS_FLAGS, 32'hfd);
	endtask : t_errors

	task automatic t_tokens;
		int i;
		wb(1'h1, UIF_OFS_ENABLES, 32'h08);
		for (i = 0; i < 4; i++) begin
			e = '0;
			e.token_done = 1'h1;
			t.endpoint = 4'(i * 5);
			t.dir_tx = i[0];
			t.odd_bank = i[1];
			pm.pulse(e, t);
		end
		repeat (2) @(posedge clk);
		chk("fifo full", full, 32'h1);
		chk("token irq", irq, 32'h1);
		for (i = 0; i < 4; i++) begin
			wb(1'h0, UIF_OFS_FLAGS, 32'h0);
			chk("token flag", rd[3], 32'h1);
			chk("status", tstat, {4'(i * 5), i[0], i[1], 2'h0});
			wb(1'h1, UIF_OFS_FLAGS, 32'h08);
			repeat (2) @(posedge clk);
		end
		wb(1'h0, UIF_OFS_FLAGS, 32'h0);
		chk("token empty", rd[3], 32'h0);
		chk("token irq off", irq, 32'h0);
	endtask : t_tokens

	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		rstn = 1'h0;
		host = 1'h0;
		cyc = 1'h0;
		stb = 1'h0;
		we = 1'h0;
		adr = 4'h0;
		sel = 4'h0;
		wdat = 32'h0;
		repeat (5) @(posedge clk);
		rstn <= 1'h1;
		@(posedge clk);
		t_reset();
		t_events();
		t_line();
		t_errors();
		t_tokens();
		results();
	end
endmodule : tb
`default_nettype wire
